/* File: shared/uep0_pkg.sv */
package uep0_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_PAYLOAD = 8'h00;
  localparam logic [7:0] A_CSR = 8'h04;
  localparam logic [7:0] A_INDEX = 8'h08;
  localparam logic [7:0] A_IRQ_STAT = 8'h0c;
  localparam logic [7:0] A_IRQ_CLR = 8'h10;
  localparam logic [7:0] A_IRQ_EN = 8'h14;

  // ----------------------------------------------------------------
  // Field layout and widths
  // ----------------------------------------------------------------
  localparam int PAYLOAD_W = 11;
  localparam int INDEX_W = 4;
  localparam int IRQ_W = 4;
  localparam logic [3:0] EP_ZERO = 4'h0;
  // Control/status bits of endpoint 0
  localparam int B_RXRDY = 0;
  localparam int B_TXRDY = 1;
  localparam int B_SENT_STALL = 2;
  localparam int B_DATA_END = 3;
  localparam int B_SETUP_END = 4;
  localparam int B_SEND_STALL = 5;
  localparam int B_SERV_RX = 6;
  localparam int B_SERV_SETUP = 7;
  localparam int B_FLUSH = 8;
  // Interrupt status bits
  localparam int I_RX = 0;
  localparam int I_TX = 1;
  localparam int I_SETUP = 2;
  localparam int I_STALL = 3;
  // Reset values
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam logic [PAYLOAD_W-1:0] PAYLOAD_RST = 11'h000;

  // ----------------------------------------------------------------
  // Carriers between this block and the packet engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rx_pkt;      // Data packet received on endpoint 0
    logic tx_done;     // Queued packet has been transmitted
    logic stall_done;  // STALL handshake has gone out
    logic ctrl_end;    // Control transfer has ended
  } uep0_ev_t;

  typedef struct packed {
    logic tx_ready;    // Packet waits in the FIFO
    logic stall_req;   // Answer the current transaction with STALL
    logic data_end;    // Last data packet of the transfer
    logic flush;       // One-cycle pulse: discard packet, reset pointer
  } uep0_cmd_t;

endpackage

/* File: src/uep0_ctrl.sv */
`timescale 1ns/1ps

// Functional notes
// - Hold 11-bit transmit payload limit, up to 2047
// - Flush discards packet, resets pointer, clears ready
// - Flush ignored unless a ready flag set
// - Setup-end acknowledge clears setup-end flag, self-clears
// - Receive-serviced strobe or a flush clears receive ready flag
// - Stall request sends STALL then self-clears
// - Early transfer end sets flag, interrupts, flushes
// - Stall-sent flag set on STALL, software clears
// - Software sets transmit ready; device clears when sent
// - Transmit-ready clear on send raises enabled endpoint interrupt; a flush clear raises none
// - Received packet sets receive ready, raises interrupt
module uep0_ctrl
  import uep0_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Packet engine side
  input wire uep0_ev_t link_ev,
  output uep0_cmd_t link_cmd,
  output logic [PAYLOAD_W-1:0] payload_limit,
  output logic [INDEX_W-1:0] endpoint_select,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic [PAYLOAD_W-1:0] limit_q;
  logic [INDEX_W-1:0] index_q;
  logic rxr_q, rxr_d, txr_q, txr_d;
  logic stall_q, stall_d, ssent_q, ssent_d;
  logic setup_q, setup_d, dend_q, dend_d;
  logic flush_q;
  logic [IRQ_W-1:0] stat_q, stat_d, en_q;
  logic irq_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Access phase waits one cycle so every bus output is a flop
  wire acc_first = psel & penable & ~pready_q;
  wire acc_done = psel & penable & pready_q;
  wire wr_en = acc_done & pwrite;
  wire aligned = (paddr[1:0] == 2'b00);
  wire sel_pay = aligned & (paddr == A_PAYLOAD);
  wire sel_idx = aligned & (paddr == A_INDEX);
  wire sel_stat = aligned & (paddr == A_IRQ_STAT);
  wire sel_clr = aligned & (paddr == A_IRQ_CLR);
  wire sel_en = aligned & (paddr == A_IRQ_EN);
  wire sel_csr_raw = aligned & (paddr == A_CSR);
  // Endpoint 0 set only appears while index selects it
  wire sel_csr = sel_csr_raw & (index_q == EP_ZERO);
  wire mapped = sel_pay | sel_idx | sel_stat | sel_clr | sel_en |
                sel_csr_raw;
  wire csr_wr = wr_en & sel_csr;
  wire [15:0] wd = pwdata[15:0];

  // ----------------------------------------------------------------
  // Endpoint 0 handshake terms
  // ----------------------------------------------------------------
  // flush gating by flags
  wire flush_sw = csr_wr & wd[B_FLUSH] & (txr_q | rxr_q);
  wire early_end = link_ev.ctrl_end & ~dend_q;
  wire flush_now = flush_sw | early_end;
  wire serv_rx = csr_wr & wd[B_SERV_RX];
  wire serv_setup = csr_wr & wd[B_SERV_SETUP];
  // Only a written zero clears the stall-sent flag
  wire clr_ssent = csr_wr & ~wd[B_SENT_STALL];
  wire tx_fin = link_ev.tx_done & txr_q;

  // ----------------------------------------------------------------
  // Next-state logic; a hardware set always beats a clear
  // ----------------------------------------------------------------
  // receive flag set
  assign rxr_d = link_ev.rx_pkt | (rxr_q & ~serv_rx & ~flush_now);
  assign txr_d = (csr_wr & wd[B_TXRDY]) |
                 (txr_q & ~link_ev.tx_done & ~flush_now);
  // stall request held until handshake out
  assign stall_d = (csr_wr & wd[B_SEND_STALL]) |
                   (stall_q & ~link_ev.stall_done);
  assign ssent_d = link_ev.stall_done | (ssent_q & ~clr_ssent);
  assign setup_d = early_end | (setup_q & ~serv_setup);
  // data end cleared by device at end of stage
  assign dend_d = (csr_wr & wd[B_DATA_END]) |
                  (dend_q & ~link_ev.tx_done & ~link_ev.ctrl_end);

  // Interrupt events, sticky until the clear register is written
  wire [IRQ_W-1:0] ev_vec = {link_ev.stall_done, early_end, tx_fin,
                             link_ev.rx_pkt};
  wire [IRQ_W-1:0] clr_vec = (wr_en & sel_clr) ? pwdata[IRQ_W-1:0]
                                               : '0;
  assign stat_d = ev_vec | (stat_q & ~clr_vec);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // strobes and reserved bits read zero
  wire [15:0] csr_rd = {11'h000, setup_q, 1'b0, ssent_q, txr_q, rxr_q};
  wire [31:0] rd_val =
    sel_pay ? {21'h000000, limit_q} :
    sel_csr ? {16'h0000, csr_rd} :
    sel_idx ? {28'h0000000, index_q} :
    sel_stat ? {28'h0000000, stat_q} :
    sel_en ? {28'h0000000, en_q} : RD_ZERO;

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= RD_ZERO;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= acc_first;
      prdata_q <= (acc_first & ~pwrite) ? rd_val : RD_ZERO;
      pslverr_q <= acc_first & ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // Software-owned settings
  // ----------------------------------------------------------------
  // payload limit store; software keeps it legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_q <= PAYLOAD_RST;
      index_q <= EP_ZERO;
      en_q <= '0;
    end else begin
      if (wr_en & sel_pay) limit_q <= pwdata[PAYLOAD_W-1:0];
      if (wr_en & sel_idx) index_q <= pwdata[INDEX_W-1:0];
      if (wr_en & sel_en) en_q <= pwdata[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Endpoint 0 flags
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxr_q <= 1'b0;
      txr_q <= 1'b0;
      stall_q <= 1'b0;
      ssent_q <= 1'b0;
      setup_q <= 1'b0;
      dend_q <= 1'b0;
    end else begin
      rxr_q <= rxr_d;
      txr_q <= txr_d;
      stall_q <= stall_d;
      ssent_q <= ssent_d;
      setup_q <= setup_d;
      dend_q <= dend_d;
    end
  end

  // ----------------------------------------------------------------
  // Flush pulse and interrupt
  // ----------------------------------------------------------------
  // flush pulse resets FIFO pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush_q <= 1'b0;
      stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      flush_q <= flush_now;
      stat_q <= stat_d;
      irq_q <= |(stat_q & en_q); // one cycle behind status
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign link_cmd = '{tx_ready: txr_q, stall_req: stall_q,
                      data_end: dend_q, flush: flush_q};
  assign payload_limit = limit_q;
  assign endpoint_select = index_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_flush_clears_flags: assert property (
    flush_sw & ~link_ev.rx_pkt & ~(wd[B_TXRDY])
      |=> !rxr_q && !txr_q && flush_q)
    else $error("flush left a ready flag set");

  a_flush_needs_flag: assert property (
    csr_wr & wd[B_FLUSH] & ~txr_q & ~rxr_q & ~early_end
      |=> !flush_q)
    else $error("flush fired with no ready flag");

  a_setup_ack_clears: assert property (
    serv_setup & ~early_end |=> !setup_q)
    else $error("setup-end flag survived acknowledge");

  a_rx_only_by_serv: assert property (
    rxr_q & ~serv_rx & ~flush_now |=> rxr_q)
    else $error("receive flag cleared without service");

  a_stall_self_clears: assert property (
    stall_q & link_ev.stall_done & ~(csr_wr & wd[B_SEND_STALL])
      |=> !link_cmd.stall_req ##0 ssent_q)
    else $error("stall request not cleared after handshake");

  a_early_end_flag: assert property (
    link_ev.ctrl_end & ~dend_q
      |=> setup_q && stat_q[I_SETUP] && flush_q)
    else $error("early end did not flag and flush");

  a_stall_sent_sticky: assert property (
    ssent_q & ~clr_ssent |=> ssent_q)
    else $error("stall-sent flag dropped by itself");

  a_tx_done_irq: assert property (
    tx_fin & en_q[I_TX] & ~(wr_en & sel_en) & ~(wr_en & sel_clr) &
      ~(csr_wr & wd[B_TXRDY])
      |=> !txr_q ##1 irq)
    else $error("transmit completion gave no interrupt");

  a_rx_sets_flag: assert property (
    link_ev.rx_pkt |=> rxr_q && stat_q[I_RX])
    else $error("receive packet not flagged");

  a_stall_sent_set: assert property (
    link_ev.stall_done |=> ssent_q && stat_q[I_STALL])
    else $error("stall handshake not flagged");

  a_dend_auto_clear: assert property (
    dend_q & (link_ev.tx_done | link_ev.ctrl_end) &
      ~(csr_wr & wd[B_DATA_END])
      |=> !dend_q)
    else $error("data end outlived its stage");

  a_tx_sw_set: assert property (
    csr_wr & wd[B_TXRDY] |=> txr_q)
    else $error("transmit ready write did not set flag");

  // A zero written to a set-only bit must leave the flag alone
  a_zero_write_keeps: assert property (
    csr_wr & ~wd[B_TXRDY] & txr_q & ~link_ev.tx_done & ~flush_now
      |=> txr_q)
    else $error("zero write cleared transmit ready");

  a_strobes_read_zero: assert property (
    acc_first & ~pwrite & sel_csr
      |=> !prdata[B_DATA_END] && !prdata[B_SEND_STALL] &&
          !prdata[B_SERV_RX] && !prdata[B_SERV_SETUP] && !prdata[B_FLUSH])
    else $error("write-only strobe bit read back as one");

  // The level output trails status by one register stage
  a_irq_level: assert property (
    |(stat_q & en_q) |=> irq)
    else $error("enabled status bit gave no interrupt");

  a_irq_quiet: assert property (
    ~|(stat_q & en_q) |=> !irq)
    else $error("interrupt with no enabled status bit");

  a_bad_addr_err: assert property (
    acc_first & ~mapped |=> pready && pslverr)
    else $error("unmapped access answered without error");

  a_apb_one_wait: assert property (
    psel & penable & ~pready |=> pready ##1 !pready)
    else $error("APB answer not after one wait");

  c_tx_round: cover property (
    csr_wr & wd[B_TXRDY] ##[1:20] tx_fin);
  c_stall_round: cover property (
    stall_q ##[1:20] ssent_q);
  c_early_end: cover property (early_end ##2 irq);
  c_tx_flush: cover property (flush_sw & txr_q);

endmodule

/* File: dv/uep0_host_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side of the link: answers packets and stalls
// ------------------------------------------------------------
module uep0_host_model
  import uep0_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Device side
  input wire uep0_cmd_t link_cmd,
  output uep0_ev_t link_ev,
  // Bench control
  input wire uep0_ev_t inject,
  input wire logic [3:0] tx_wait
);
  logic [3:0] cnt_q;
  logic busy_q;
  // Busy keeps a second pulse out while the flag is falling
  wire tx_go = link_cmd.tx_ready && !busy_q && cnt_q == tx_wait;
  wire st_go = link_cmd.stall_req && !busy_q;
  wire [3:0] cnt_d = (link_cmd.tx_ready && !tx_go) ? cnt_q + 4'h1 : 4'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      link_ev <= '0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= tx_go | st_go;
      link_ev <= inject | {1'b0, tx_go, st_go, 1'b0};
    end
  end
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import uep0_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  uep0_ev_t link_ev, inject;
  uep0_cmd_t link_cmd;
  logic [PAYLOAD_W-1:0] payload_limit;
  logic [INDEX_W-1:0] endpoint_select;
  logic [3:0] tx_wait;
  logic err;
  int miscompares, compares, flush_cnt, stall_cnt;
  uep0_ctrl DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_ev(link_ev), .link_cmd(link_cmd), .payload_limit(payload_limit),
    .endpoint_select(endpoint_select), .irq(irq));
  uep0_host_model host (.pclk(pclk), .presetn(presetn),
    .link_cmd(link_cmd), .link_ev(link_ev), .inject(inject),
    .tx_wait(tx_wait));
  // Pulse and request watchers
  always @(posedge pclk) begin
    if (link_cmd.flush === 1'b1) flush_cnt++;
    if (link_cmd.stall_req === 1'b1) stall_cnt++;
  end
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic print_verdict();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer; a wait that runs out ends the run
  task automatic apb(input logic [7:0] a, input logic w,
      input logic [31:0] d);
    int n;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) begin
      miscompares++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    `CHK(rd, e)
  endtask
  // Event from the host, then let it land in the flags
  task automatic ev(input uep0_ev_t e);
    @(posedge pclk);
    inject <= e;
    @(posedge pclk);
    inject <= '0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic settle();
    repeat (2) @(negedge pclk);
  endtask
  // Wait for the host to take the packet; running out ends the run
  task automatic wait_tx();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (link_cmd.tx_ready !== 1'b0 && n < 40);
    if (n >= 40) begin
      miscompares++;
      print_verdict();
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    inject = '0;
    tx_wait = 4'h3;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) chk(8'(i * 4), RD_ZERO);
    wr(A_PAYLOAD, 32'h0000_0400);
    chk(A_PAYLOAD, 32'h0000_0400);
    wr(A_PAYLOAD, 32'hffff_ffff);
    chk(A_PAYLOAD, 32'h0000_07ff);
    `CHK(payload_limit, 11'h7ff)
    chk(8'h18, RD_ZERO);
    `CHK(err, 1'b1)
    wr(A_IRQ_EN, 32'h0000_000f);
    wr(A_CSR, 32'h0000_0100);
    chk(A_CSR, RD_ZERO);
    `CHK(flush_cnt, 0)
    // Receive, a zero write that must not clear, then service
    ev(4'h8);
    chk(A_CSR, 32'h0000_0001);
    chk(A_IRQ_STAT, 32'h0000_0001);
    `CHK(irq, 1'b1)
    wr(A_CSR, RD_ZERO);
    chk(A_CSR, 32'h0000_0001);
    wr(A_CSR, 32'h0000_0040);
    chk(A_CSR, RD_ZERO);
    wr(A_IRQ_CLR, 32'h0000_000f);
    chk(A_IRQ_STAT, RD_ZERO);
    // Transmit the last packet with data end
    wr(A_CSR, 32'h0000_000a);
    @(negedge pclk);
    `CHK(link_cmd.tx_ready, 1'b1)
    `CHK(link_cmd.data_end, 1'b1)
    wait_tx();
    chk(A_CSR, RD_ZERO);
    chk(A_IRQ_STAT, 32'h0000_0002);
    `CHK(link_cmd.data_end, 1'b0)
    `CHK(irq, 1'b1)
    wr(A_IRQ_CLR, 32'h0000_000f);
    // Stall, sticky sent flag, write-one ignored, write-zero clears
    wr(A_CSR, 32'h0000_0020);
    chk(A_CSR, 32'h0000_0004);
    `CHK(link_cmd.stall_req, 1'b0)
    `CHK(stall_cnt > 0, 1'b1)
    chk(A_IRQ_STAT, 32'h0000_0008);
    wr(A_CSR, 32'h0000_0004);
    chk(A_CSR, 32'h0000_0004);
    wr(A_CSR, RD_ZERO);
    chk(A_CSR, RD_ZERO);
    wr(A_IRQ_CLR, 32'h0000_000f);
    // Transmit done with no packet waiting raises nothing
    ev(4'h4);
    chk(A_IRQ_STAT, RD_ZERO);
    // Transfer ends early while a packet waits
    ev(4'h8);
    ev(4'h1);
    chk(A_CSR, 32'h0000_0010);
    `CHK(flush_cnt, 1)
    chk(A_IRQ_STAT, 32'h0000_0005);
    wr(A_CSR, 32'h0000_0080);
    chk(A_CSR, RD_ZERO);
    ev(4'h8);
    wr(A_CSR, 32'h0000_0100);
    chk(A_CSR, RD_ZERO);
    `CHK(flush_cnt, 2)
    // Flush a waiting transmit packet before the host takes it
    tx_wait <= 4'hf;
    wr(A_CSR, 32'h0000_0002);
    wr(A_CSR, 32'h0000_0100);
    chk(A_CSR, RD_ZERO);
    `CHK(flush_cnt, 3)
    wr(A_IRQ_EN, RD_ZERO);
    settle();
    `CHK(irq, 1'b0)
    // Another endpoint selected hides endpoint 0
    wr(A_INDEX, 32'h0000_0001);
    settle();
    `CHK(endpoint_select, 4'h1)
    ev(4'h8);
    chk(A_CSR, RD_ZERO);
    wr(A_CSR, 32'h0000_0040);
    wr(A_INDEX, RD_ZERO);
    chk(A_CSR, 32'h0000_0001);
    // Reset in mid-run clears every flag and setting
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    `CHK(payload_limit, PAYLOAD_RST)
    chk(A_CSR, RD_ZERO);
    print_verdict();
  end
endmodule
